// [design/tpw_top.sv]
// Purpose: 16-bit timer waveform generator, fast and phase-correct PWM
// Assumes: Single 125 MHz clock, register port with one-cycle read data
// Notes:   Modes outside the two PWM families hold the counter still
//
// Design decisions made here: the address-and-strobe port and the placing of the registers.

`timescale 1ns/1ps

module tpw_top (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	input  wire tpw_pkg::tpw_bus_req_t bus_req,
	output logic [tpw_pkg::DATA_W-1:0] rd_data,
	output logic                      irq,
	output tpw_pkg::tpw_pins_t        pins
);
	import tpw_pkg::*;

	tpw_state_t s_ff;
	tpw_state_t nxt_s;

	logic [3:0]          mode;
	logic [2:0]          ps_sel;
	logic [PRESC_W-1:0]  ps_lim;
	logic                tick;
	logic                fast;
	logic                phase;
	logic                fixed_top;
	logic                top_is_a;
	logic                top_is_cap;
	logic [CNT_W-1:0]    top;
	logic                at_top;
	logic                at_bot;
	logic                load;
	logic                next_up;
	logic [ST_W-1:0]     ev;
	logic [ST_W-1:0]     clr;
	logic [NUM_CH-1:0]   match;
	logic [1:0]          setting;
	logic [CNT_W-1:0]    wmask;

	// ----------------------------------------------------------------
	// Outputs straight from the state register
	// ----------------------------------------------------------------
	assign rd_data  = s_ff.rd_data;
	assign irq      = s_ff.irq;
	assign pins.out = s_ff.wave;
	assign pins.oe  = s_ff.oe;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_s      = s_ff;
		nxt_s.rd_data = '0;
		mode       = s_ff.ctrl[CTRL_MODE_LSB +: 4];
		ps_sel     = s_ff.ctrl[CTRL_PS_LSB +: 3];
		tick       = 1'b0;
		ev         = '0;
		clr        = '0;
		match      = '0;
		load       = 1'b0;
		next_up    = s_ff.up;
		setting    = SET_OFF;
		top        = TOP_8;
		fixed_top  = 1'b0;
		top_is_a   = 1'b0;
		top_is_cap = 1'b0;
		fast       = 1'b0;
		phase      = 1'b0;

		// Prescaler: factor 1 ticks every cycle, select 0 stops
		case (ps_sel)
		3'h1:    ps_lim = PS_LIM_1;
		3'h2:    ps_lim = PS_LIM_8;
		3'h3:    ps_lim = PS_LIM_64;
		3'h4:    ps_lim = PS_LIM_256;
		3'h5:    ps_lim = PS_LIM_1024;
		default: ps_lim = PS_LIM_1;
		endcase
		if (ps_sel == PS_STOP) begin
			nxt_s.presc = PS_ZERO;
		end else if (s_ff.presc >= ps_lim) begin
			nxt_s.presc = PS_ZERO;
			tick        = 1'b1;
		end else begin
			nxt_s.presc = s_ff.presc + PS_ONE;
		end

		// Top selection per mode
		case (mode)
		MODE_FAST8, MODE_PC8: begin
			top       = TOP_8;
			fixed_top = 1'b1;
		end
		MODE_FAST9, MODE_PC9: begin
			top       = TOP_9;
			fixed_top = 1'b1;
		end
		MODE_FAST10, MODE_PC10: begin
			top       = TOP_10;
			fixed_top = 1'b1;
		end
		MODE_FS_CAP, MODE_PC_CAP: begin
			// Live register, no buffer: a low write is missed
			top        = s_ff.cap;
			top_is_cap = 1'b1;
		end
		MODE_FS_A, MODE_PC_A: begin
			top      = s_ff.ocr[0];
			top_is_a = 1'b1;
		end
		default: begin
			top = TOP_8;
		end
		endcase
		fast  = (mode == MODE_FAST8) || (mode == MODE_FAST9) ||
		        (mode == MODE_FAST10) || (mode == MODE_FS_CAP) ||
		        (mode == MODE_FS_A);
		phase = (mode == MODE_PC8) || (mode == MODE_PC9) ||
		        (mode == MODE_PC10) || (mode == MODE_PC_CAP) ||
		        (mode == MODE_PC_A);
		at_top = (s_ff.cnt == top);
		at_bot = (s_ff.cnt == CNT_BOT);

		// ------------------------------------------------------------
		// Counter
		// ------------------------------------------------------------
		if (tick && fast) begin
			if (at_top) begin
				nxt_s.cnt = CNT_BOT;
				ev[ST_OVF] = 1'b1;
				ev[ST_CAP] = top_is_cap;
				load       = 1'b1;
			end else begin
				// Natural 16-bit wrap past ffff covers a missed top
				nxt_s.cnt = s_ff.cnt + CNT_ONE;
			end
		end else if (tick && phase) begin
			if (s_ff.up && at_top) begin
				next_up    = 1'b0;
				nxt_s.cnt  = s_ff.cnt - CNT_ONE;
				ev[ST_CAP] = top_is_cap;
				load       = 1'b1;
			end else if (!s_ff.up && at_bot) begin
				next_up    = 1'b1;
				nxt_s.cnt  = s_ff.cnt + CNT_ONE;
				ev[ST_OVF] = 1'b1;
			end else if (s_ff.up) begin
				nxt_s.cnt = s_ff.cnt + CNT_ONE;
			end else begin
				nxt_s.cnt = s_ff.cnt - CNT_ONE;
			end
			nxt_s.up = next_up;
		end

		// ------------------------------------------------------------
		// Compare units
		// ------------------------------------------------------------
		for (int i = 0; i < NUM_CH; i++) begin
			setting  = s_ff.ctrl[CTRL_SET_LSB + 2*i +: 2];
			match[i] = tick && (fast || phase) &&
			           (s_ff.cnt == s_ff.ocr[i]);
			ev[ST_CMP_LSB + i] = match[i];
			if (tick && fast) begin
				// Match takes priority so compare at top holds steady
				if (match[i]) begin
					if (setting == SET_NONINV)
						nxt_s.wave[i] = 1'b1;
					else if (setting == SET_INV)
						nxt_s.wave[i] = 1'b0;
					else if (setting == SET_TOGGLE && i == 0 &&
					         mode == MODE_FS_A)
						nxt_s.wave[i] = ~s_ff.wave[i];
				end else if (at_top) begin
					if (setting == SET_NONINV)
						nxt_s.wave[i] = 1'b0;
					else if (setting == SET_INV)
						nxt_s.wave[i] = 1'b1;
				end
			end else if (tick && phase && match[i]) begin
				// Direction of the step leaving this count decides
				if (setting == SET_NONINV)
					nxt_s.wave[i] = ~next_up;
				else if (setting == SET_INV)
					nxt_s.wave[i] = next_up;
				else if (setting == SET_TOGGLE && i == 0 &&
				         mode == MODE_PC_A)
					nxt_s.wave[i] = ~s_ff.wave[i];
			end
			// Port keeps the pin unless direction is output and enabled
			nxt_s.oe[i] = s_ff.dir[i] && (setting != SET_OFF);
			if (load || !(fast || phase))
				nxt_s.ocr[i] = s_ff.buff[i];
		end

		// ------------------------------------------------------------
		// Register writes
		// ------------------------------------------------------------
		wmask = fixed_top ? top : CAP_RST;
		if (bus_req.wr) begin
			case (bus_req.addr)
			OFS_CTRL:   nxt_s.ctrl = bus_req.wdata[CTRL_W-1:0];
			OFS_DIR:    nxt_s.dir  = bus_req.wdata[NUM_CH-1:0];
			OFS_COUNT:  nxt_s.cnt  = bus_req.wdata[CNT_W-1:0];
			OFS_CMP_A:  nxt_s.buff[0] =
			            bus_req.wdata[CNT_W-1:0] & wmask;
			OFS_CMP_B:  nxt_s.buff[1] =
			            bus_req.wdata[CNT_W-1:0] & wmask;
			OFS_CMP_C:  nxt_s.buff[2] =
			            bus_req.wdata[CNT_W-1:0] & wmask;
			OFS_CAPTOP: nxt_s.cap = bus_req.wdata[CNT_W-1:0];
			OFS_CLEAR:  clr = bus_req.wdata[ST_W-1:0];
			OFS_ENABLE: nxt_s.enable = bus_req.wdata[ST_W-1:0];
			default:    nxt_s.ctrl = s_ff.ctrl;
			endcase
		end

		// Sticky flags: an event in the clearing cycle still sets
		nxt_s.status = (s_ff.status & ~clr) | ev;
		nxt_s.irq    = |(nxt_s.status & nxt_s.enable);

		// ------------------------------------------------------------
		// Register reads, data in the following cycle
		// ------------------------------------------------------------
		if (bus_req.rd) begin
			case (bus_req.addr)
			OFS_CTRL:   nxt_s.rd_data[CTRL_W-1:0] = s_ff.ctrl;
			OFS_DIR:    nxt_s.rd_data[NUM_CH-1:0] = s_ff.dir;
			OFS_COUNT:  nxt_s.rd_data[CNT_W-1:0]  = s_ff.cnt;
			OFS_CMP_A:  nxt_s.rd_data[CNT_W-1:0]  = s_ff.buff[0];
			OFS_CMP_B:  nxt_s.rd_data[CNT_W-1:0]  = s_ff.buff[1];
			OFS_CMP_C:  nxt_s.rd_data[CNT_W-1:0]  = s_ff.buff[2];
			OFS_CAPTOP: nxt_s.rd_data[CNT_W-1:0]  = s_ff.cap;
			OFS_STATUS: nxt_s.rd_data[ST_W-1:0]   = s_ff.status;
			OFS_ENABLE: nxt_s.rd_data[ST_W-1:0]   = s_ff.enable;
			default:    nxt_s.rd_data = '0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			s_ff      <= '0;
			s_ff.ctrl <= CTRL_RST;
			s_ff.up   <= 1'b1;
			s_ff.cap  <= CAP_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

endmodule

// [inc/tpw_pkg.sv]
// Purpose: Shared constants and types for the 16-bit PWM timer block
// Assumes: 32-bit register port, byte addresses, one word per register
// Notes:   Channel 0 is channel A, the one that may also define top

package tpw_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH    = 3;
	localparam int CNT_W     = 16;
	localparam int ADDR_W    = 8;
	localparam int DATA_W    = 32;
	localparam int PRESC_W   = 10;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DIR     = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_CMP_A   = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_CMP_B   = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_CMP_C   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_CAPTOP  = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_CLEAR   = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h24;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB  = 0;
	localparam int CTRL_SET_LSB   = 4;
	localparam int CTRL_PS_LSB    = 10;
	localparam int CTRL_W         = 13;
	localparam logic [CTRL_W-1:0] CTRL_RST = 13'h0000;

	// ----------------------------------------------------------------
	// Status bit positions (status, clear and enable share them)
	// ----------------------------------------------------------------
	localparam int ST_OVF     = 0;
	localparam int ST_CMP_LSB = 1;
	localparam int ST_CAP     = 4;
	localparam int ST_W       = 5;

	// ----------------------------------------------------------------
	// Waveform mode codes
	// ----------------------------------------------------------------
	localparam logic [3:0] MODE_PC8    = 4'h1;
	localparam logic [3:0] MODE_PC9    = 4'h2;
	localparam logic [3:0] MODE_PC10   = 4'h3;
	localparam logic [3:0] MODE_FAST8  = 4'h5;
	localparam logic [3:0] MODE_FAST9  = 4'h6;
	localparam logic [3:0] MODE_FAST10 = 4'h7;
	localparam logic [3:0] MODE_PC_CAP = 4'ha;
	localparam logic [3:0] MODE_PC_A   = 4'hb;
	localparam logic [3:0] MODE_FS_CAP = 4'he;
	localparam logic [3:0] MODE_FS_A   = 4'hf;

	// Fixed tops
	localparam logic [CNT_W-1:0] TOP_8   = 16'h00ff;
	localparam logic [CNT_W-1:0] TOP_9   = 16'h01ff;
	localparam logic [CNT_W-1:0] TOP_10  = 16'h03ff;
	localparam logic [CNT_W-1:0] CNT_BOT = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
	localparam logic [CNT_W-1:0] CAP_RST = 16'hffff;

	// Compare output settings
	localparam logic [1:0] SET_OFF    = 2'h0;
	localparam logic [1:0] SET_TOGGLE = 2'h1;
	localparam logic [1:0] SET_NONINV = 2'h2;
	localparam logic [1:0] SET_INV    = 2'h3;

	// Prescaler limits (factor minus one); select 0 stops the timer
	localparam logic [2:0] PS_STOP = 3'h0;
	localparam logic [PRESC_W-1:0] PS_LIM_1    = 10'h000;
	localparam logic [PRESC_W-1:0] PS_LIM_8    = 10'h007;
	localparam logic [PRESC_W-1:0] PS_LIM_64   = 10'h03f;
	localparam logic [PRESC_W-1:0] PS_LIM_256  = 10'h0ff;
	localparam logic [PRESC_W-1:0] PS_LIM_1024 = 10'h3ff;
	localparam logic [PRESC_W-1:0] PS_ZERO     = 10'h000;
	localparam logic [PRESC_W-1:0] PS_ONE      = 10'h001;

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} tpw_bus_req_t;

	typedef struct packed {
		logic [NUM_CH-1:0] out;
		logic [NUM_CH-1:0] oe;
	} tpw_pins_t;

	typedef struct packed {
		logic [CTRL_W-1:0]                 ctrl;
		logic [NUM_CH-1:0]                 dir;
		logic [CNT_W-1:0]                  cnt;
		logic                              up;
		logic [NUM_CH-1:0][CNT_W-1:0]      ocr;
		logic [NUM_CH-1:0][CNT_W-1:0]      buff;
		logic [CNT_W-1:0]                  cap;
		logic [ST_W-1:0]                   status;
		logic [ST_W-1:0]                   enable;
		logic [PRESC_W-1:0]                presc;
		logic [NUM_CH-1:0]                 wave;
		logic [NUM_CH-1:0]                 oe;
		logic [DATA_W-1:0]                 rd_data;
		logic                              irq;
	} tpw_state_t;

endpackage

// [verif/tpw_load.sv]
// Purpose: Load on the waveform pins, counts high cycles per pin
// Assumes: Pins have pull-ups when the block does not drive them
// Notes:   Counters are free-running; the bench takes differences

`timescale 1ns/1ps

module tpw_load (
	input  wire logic                              core_clk,
	input  wire logic                              rst,
	input  wire tpw_pkg::tpw_pins_t                pins,
	output logic [tpw_pkg::NUM_CH-1:0][15:0]       hi_cnt
);
	import tpw_pkg::*;

	logic [NUM_CH-1:0] level;

	// Undriven pin floats to the pull-up, never the stale waveform
	assign level = (pins.oe & pins.out) | ~pins.oe;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hi_cnt <= '0;
		end else begin
			for (int i = 0; i < NUM_CH; i++) begin
				hi_cnt[i] <= hi_cnt[i] + 16'(level[i]);
			end
		end
	end
endmodule

// [verif/tpw_props.sv]
// Purpose: Port-level checker for the PWM timer block
// Assumes: One clock domain, software mode mirrored from CTRL writes
// Notes:   Sees only the ports of tpw_top

`timescale 1ns/1ps

module tpw_props (
	input wire logic                       core_clk,
	input wire logic                       rst,
	input wire tpw_pkg::tpw_bus_req_t      bus_req,
	input wire logic [tpw_pkg::DATA_W-1:0] rd_data,
	input wire logic                       irq,
	input wire tpw_pkg::tpw_pins_t         pins
);
	import tpw_pkg::*;

	// ----------------------------------------------------------------
	// Mirror of the control fields written by software
	// ----------------------------------------------------------------
	logic [3:0] mode_ff;
	logic [2:0] ps_ff;
	logic       rd_cnt;
	logic       en_wr;
	logic       dir_wr;

	assign rd_cnt = bus_req.rd && bus_req.addr == OFS_COUNT;
	assign en_wr  = bus_req.wr && bus_req.addr == OFS_ENABLE;
	assign dir_wr = bus_req.wr && bus_req.addr == OFS_DIR;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_ff <= 4'h0;
			ps_ff   <= 3'h0;
		end else if (bus_req.wr && bus_req.addr == OFS_CTRL) begin
			mode_ff <= bus_req.wdata[3:0];
			ps_ff   <= bus_req.wdata[12:10];
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_rd_idle;
		!bus_req.rd |=> rd_data == '0;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("read data not zero outside answer");

	property p_unmapped;
		bus_req.rd && bus_req.addr == 8'h30 |=> rd_data == '0;
	endproperty
	a_unmapped: assert property (p_unmapped)
		else $error("unmapped read not zero");

	property p_status_w;
		bus_req.rd && bus_req.addr == OFS_STATUS |=> rd_data[31:5] == '0;
	endproperty
	a_status_w: assert property (p_status_w)
		else $error("status upper bits set");

	property p_irq_st;
		bus_req.rd && bus_req.addr == OFS_STATUS && irq
			|=> rd_data[4:0] != 5'h00;
	endproperty
	a_irq_st: assert property (p_irq_st)
		else $error("interrupt high with empty status");

	property p_irq_off;
		en_wr && bus_req.wdata[4:0] == 5'h00 ##1 !en_wr |=> !irq;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("interrupt high with all enables off");

	property p_oe_off;
		dir_wr && bus_req.wdata[2:0] == 3'h0 ##1 !dir_wr |=> pins.oe == 3'h0;
	endproperty
	a_oe_off: assert property (p_oe_off)
		else $error("pin driven while direction is input");

	property p_mask;
		bus_req.wr && bus_req.addr == OFS_CMP_B && mode_ff == MODE_FAST8
			##2 bus_req.rd && bus_req.addr == OFS_CMP_B
			|=> rd_data[31:8] == '0;
	endproperty
	a_mask: assert property (p_mask)
		else $error("compare bits above resolution kept");

	// Window wants reads three cycles apart, so it spans three ticks; bench reads land two cycles apart
	property p_run;
		rd_cnt && mode_ff == MODE_FAST8 && ps_ff == 3'h1
			##1 !bus_req.wr [*2] ##1 rd_cnt
			|=> rd_data[15:0] ==
			    (($past(rd_data[15:0], 3) + 16'h3) & 16'h00ff);
	endproperty
	a_run: assert property (p_run)
		else $error("fast count step wrong");

	property p_stop;
		rd_cnt && ps_ff == 3'h0 ##1 !bus_req.wr [*2] ##1 rd_cnt
			|=> rd_data == $past(rd_data, 3);
	endproperty
	a_stop: assert property (p_stop)
		else $error("count moved while timer stopped");

	c_mask: cover property (p_mask);
	c_run: cover property (p_run);
	c_irq: cover property ($rose(irq));
endmodule

// [verif/tpw_top_tb.sv]
// Purpose: Self-checking bench for the PWM timer block
// Assumes: Overflow is the only enabled interrupt during the rows
// Notes:   Periods are timed between overflow interrupts

`timescale 1ns/1ps

module tpw_top_tb;
	import tpw_pkg::*;

	typedef struct {
		logic [12:0] ctrl;
		logic [15:0] cmp;
		logic [2:0]  dir;
		int          ch;
		int          per;
		int          hi;
		logic [4:0]  stm;
	} tpw_row_t;

	logic                     core_clk;
	logic                     rst;
	tpw_bus_req_t             bus_req;
	logic [DATA_W-1:0]        rd_data;
	logic [DATA_W-1:0]        rd_q;
	logic                     irq;
	tpw_pins_t                pins;
	logic [NUM_CH-1:0][15:0]  hi_cnt;
	int                       fail_count;
	int                       samples_checked;
	int                       cyc;
	int                       t_ovf;

	// Hi counts cover two periods; ctrl = ps<<10|setB<<6|setA<<4|mode
	tpw_row_t rows [16] = '{
		'{13'h0485, 16'h0040, 3'h2, 1, 256, 382, 5'h01},
		'{13'h04c5, 16'h0040, 3'h2, 1, 256, 130, 5'h01},
		'{13'h0485, 16'h00ff, 3'h2, 1, 256, 512, 5'h01},
		'{13'h0485, 16'h0000, 3'h2, 1, 256, 510, 5'h01},
		'{13'h0485, 16'h0040, 3'h0, 1, 256, 512, 5'h01},
		'{13'h0486, 16'h0040, 3'h2, 1, 512, 894, 5'h01},
		'{13'h0487, 16'h0040, 3'h2, 1, 1024, 1918, 5'h01},
		'{13'h0481, 16'h0040, 3'h2, 1, 510, 256, 5'h01},
		'{13'h04c1, 16'h0040, 3'h2, 1, 510, 764, 5'h01},
		'{13'h0482, 16'h0040, 3'h2, 1, 1022, 256, 5'h01},
		'{13'h0483, 16'h0040, 3'h2, 1, 2046, 256, 5'h01},
		'{13'h048e, 16'h0008, 3'h2, 1, 17, 16, 5'h11},
		'{13'h048a, 16'h0008, 3'h2, 1, 32, 32, 5'h11},
		'{13'h041f, 16'h0004, 3'h1, 0, 8, 8, 5'h03},
		'{13'h048b, 16'h0004, 3'h2, 1, 14, 16, 5'h03},
		'{13'h0885, 16'h0040, 3'h2, 1, 2048, 3056, 5'h01}
	};

	tpw_top dut (
		.core_clk(core_clk),
		.rst(rst),
		.bus_req(bus_req),
		.rd_data(rd_data),
		.irq(irq),
		.pins(pins)
	);

	tpw_load u_load (
		.core_clk(core_clk),
		.rst(rst),
		.pins(pins),
		.hi_cnt(hi_cnt)
	);

	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	task print_verdict;
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Whole run needs about 45k cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			fail_count++;
			print_verdict;
		end
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
		@(posedge core_clk);
		bus_req <= '0;
		@(negedge core_clk);
		rd_q = rd_data;
	endtask

	// Clear all flags, then wait for the next overflow interrupt
	task next_ovf;
		int n;
		n = 0;
		bus(1'b1, OFS_CLEAR, 32'h1f);
		while (irq !== 1'b1 && n < 5000) begin
			@(negedge core_clk);
			n++;
		end
		chk({31'h0, irq}, 32'h1);
		t_ovf = cyc;
	endtask

	task run_row(input tpw_row_t r);
		logic [15:0] h0;
		int          t1;
		bus(1'b1, OFS_CTRL, {19'h0, r.ctrl});
		bus(1'b1, OFS_COUNT, 32'h0);
		bus(1'b1, OFS_DIR, {29'h0, r.dir});
		bus(1'b1, OFS_CMP_B, {16'h0, r.cmp});
		next_ovf;
		next_ovf;
		t1 = t_ovf;
		h0 = hi_cnt[r.ch];
		next_ovf;
		next_ovf;
		chk(32'(t_ovf - t1), 32'(2 * r.per));
		chk({16'h0, 16'(hi_cnt[r.ch] - h0)}, 32'(r.hi));
		bus(1'b0, OFS_STATUS, 32'h0);
		chk({27'h0, rd_q[4:0] & r.stm}, {27'h0, r.stm});
		$display("row ctrl %h finished", r.ctrl);
	endtask

	initial begin
		logic [7:0]  ra [5];
		logic [31:0] re [5];
		int          t1;
		logic [2:0]  psx [3];
		logic [31:0] pse [3];
		logic [7:0]  c0;
		ra = '{OFS_CTRL, OFS_CAPTOP, OFS_STATUS, OFS_CLEAR, 8'h30};
		re = '{32'h0, 32'h0000ffff, 32'h0, 32'h0, 32'h0};
		// Slow prescale selects, ticks expected in a 2048-cycle window
		psx = '{3'h3, 3'h4, 3'h5};
		pse = '{32'd32, 32'd8, 32'd2};
		rst = 1'b1;
		bus_req = '0;
		fail_count = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (3) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		chk({25'h0, irq, pins.oe, pins.out}, 32'h0);
		foreach (ra[i]) begin
			bus(1'b0, ra[i], 32'h0);
			chk(rd_q, re[i]);
		end
		$display("reset values finished");

		bus(1'b1, OFS_CMP_A, 32'h7);
		bus(1'b1, OFS_CAPTOP, 32'h10);
		bus(1'b1, OFS_ENABLE, 32'h1);
		foreach (rows[i]) begin
			run_row(rows[i]);
		end

		bus(1'b1, OFS_CTRL, 32'h0405);
		bus(1'b1, OFS_COUNT, 32'h0);
		bus(1'b0, OFS_COUNT, 32'h0);
		bus(1'b0, OFS_COUNT, 32'h0);
		bus(1'b1, OFS_CMP_B, 32'hffff);
		bus(1'b0, OFS_CMP_B, 32'h0);
		chk(rd_q, 32'h00ff);
		$display("compare masking finished");

		bus(1'b1, OFS_CTRL, 32'h040e);
		bus(1'b1, OFS_COUNT, 32'hfff0);
		bus(1'b1, OFS_CLEAR, 32'h1f);
		bus(1'b0, OFS_COUNT, 32'h0);
		chk({31'h0, rd_q[15:0] >= 16'hfff0}, 32'h1);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk({31'h0, rd_q[0]}, 32'h0);
		next_ovf;
		$display("capture top wrap finished");

		bus(1'b1, OFS_CTRL, 32'h040f);
		bus(1'b1, OFS_COUNT, 32'h0);
		next_ovf;
		t1 = t_ovf;
		bus(1'b1, OFS_CMP_A, 32'h1f);
		next_ovf;
		chk(32'(t_ovf - t1), 32'd8);
		t1 = t_ovf;
		next_ovf;
		chk(32'(t_ovf - t1), 32'd32);
		$display("buffered top finished");

		// Selects rise in order so the divider never sits above its limit
		foreach (psx[i]) begin
			bus(1'b1, OFS_CTRL, {19'h0, psx[i], 10'h005});
			bus(1'b0, OFS_COUNT, 32'h0);
			c0 = rd_q[7:0];
			repeat (2046) @(posedge core_clk);
			bus(1'b0, OFS_COUNT, 32'h0);
			chk({24'h0, rd_q[7:0] - c0}, pse[i]);
		end
		$display("slow prescale finished");

		bus(1'b1, OFS_CTRL, 32'h0);
		bus(1'b1, OFS_ENABLE, 32'h0);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk({31'h0, rd_q[0]}, 32'h1);
		chk({31'h0, irq}, 32'h0);
		bus(1'b1, OFS_CLEAR, 32'h1f);
		bus(1'b0, OFS_STATUS, 32'h0);
		chk(rd_q, 32'h0);
		bus(1'b0, OFS_COUNT, 32'h0);
		t1 = int'(rd_q);
		bus(1'b0, OFS_COUNT, 32'h0);
		chk(rd_q, 32'(t1));
		$display("masking and stop finished");

		// Reset in mid-run must restore capture top and direction
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(negedge core_clk);
		chk({25'h0, irq, pins.oe, pins.out}, 32'h0);
		bus(1'b0, OFS_CAPTOP, 32'h0);
		chk(rd_q, 32'h0000ffff);
		bus(1'b0, OFS_DIR, 32'h0);
		chk(rd_q, 32'h0);
		$display("second reset finished");
		print_verdict;
	end
endmodule

bind tpw_top tpw_props u_props (
	.core_clk(core_clk),
	.rst(rst),
	.bus_req(bus_req),
	.rd_data(rd_data),
	.irq(irq),
	.pins(pins)
);
